// *** rtl/pcm_rx_shifter.v ***
// Purpose: Receive shift register, first bit ends up most significant.
// Assumes: Clear and capture are one-cycle strobes.
// Notes: A short word sits in the low bits.
`timescale 1ns/10ps
`default_nettype none
module pcm_rx_shifter (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Control
	input wire clear_i,
	input wire capture_i,
	input wire bit_i,
	// Parallel side
	output wire [15:0] word_o
);
	reg [15:0] sr;

	// Shift in at the bottom
	always @(posedge ref_clk_i) begin
		if (rst_i || clear_i) begin
			sr <= 16'h0000;
		end else if (capture_i) begin
			sr <= {sr[14:0], bit_i};
		end
	end

	assign word_o = sr;
endmodule
`default_nettype wire

// *** rtl/pcm_tx_shifter.v ***
// Purpose: Transmit shift register, most significant bit leaves first.
// Assumes: Load and shift are one-cycle strobes, never together.
// Notes: The output bit comes straight from the register.
`timescale 1ns/10ps
`default_nettype none
module pcm_tx_shifter (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Control
	input wire load_i,
	input wire shift_i,
	input wire [15:0] word_i,
	// Serial side
	output wire serial_o
);
	reg [15:0] sr;

	// Load left-justified word, shift towards the top
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			sr <= 16'h0000;
		end else if (load_i) begin
			sr <= word_i;
		end else if (shift_i) begin
			sr <= {sr[14:0], 1'b0};
		end
	end

	assign serial_o = sr[15];
endmodule
`default_nettype wire

// *** rtl/voice_codec_consts.vh ***
// Purpose: Shared constants of the voice codec PCM serial port.
// Assumes: 250 MHz reference clock, 2.048 MHz master clock, 8 kHz frames.
// Notes: Included by bare name from the PCM port design file only.
//
// Behaviour
// - Words shift most significant bit first.
// - Eight bits companded, sixteen bits linear.
// - Bit clock input high selects fixed rate.
// - Fixed rate launches on master rising edges.
// - Fixed rate captures on master falling edges.
// - Data out driven bit 1 until last.
// - Slot strobe low from bit 1 until last.
// - Variable rate: bit 1 on sync, rest clocked.
// - Variable rate releases data on sync fall.
// - Outputs float three frames after power up, drive in the fourth.
// - Master clock loss floats both outputs.
// - Power down ignores syncs, floats outputs.
// - Undriven power down input reads as high.
// - Both syncs idle puts device in standby.
// - Transmit sync idle floats transmit outputs.
// - Receive sync idle stops only receive side.
// - Linear: 13 sample bits, 3 trailing bits.
// - Toggling receive bit clock selects variable rate.
// - Variable rate repeats word while sync high.
`ifndef VOICE_CODEC_CONSTS_VH
`define VOICE_CODEC_CONSTS_VH

// ----------------------------------------
// Word format
// ----------------------------------------
`define WORD_LEN_COMPANDED 5'h08
`define WORD_LEN_LINEAR 5'h10
`define ATTEN_BITS 3
`define SAMPLE_BITS 13

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_PERIOD_NS 4
`define CLK_LOSS_TIME_NS 1000
`define CLK_LOSS_CYCLES 8'hfa // 1000 ns of reference clock
`define FRAME_MCLK 9'h100
`define WARMUP_FRAMES 3'h4

`endif

// *** rtl/voice_codec_pcm_port.v ***
// Purpose: PCM serial port and power state control of a voice codec.
// Assumes: All pins sampled synchronously on the 250 MHz reference clock.
// Notes: Pin clocks are seen as edges of sampled levels, not as clocks.
`timescale 1ns/10ps
`default_nettype none
`include "voice_codec_consts.vh"
module voice_codec_pcm_port (
	// Clock and reset
	input wire ref_clk_i,
	input wire rst_i,
	// Codec pins from the serial port
	input wire master_clk_i,
	input wire transmit_frame_sync_i,
	input wire receive_frame_sync_i,
	input wire transmit_bit_clock_i,
	input wire receive_bit_clock_i,
	input wire serial_data_in_i,
	input wire power_down_n_i,
	input wire power_down_n_oe_i,
	input wire linear_mode_i,
	// Codec pins to the serial port
	output wire serial_data_out_o,
	output wire serial_data_out_oe_o,
	output wire transmit_slot_strobe_n_o,
	output wire transmit_slot_strobe_n_oe_o,
	// Converter side, transmit
	input wire [15:0] tx_word_i,
	output reg tx_word_taken_o,
	// Converter side, receive
	output reg [12:0] rx_sample_o,
	output reg [2:0] rx_attenuation_o,
	output reg rx_word_valid_o,
	// Status
	output reg variable_rate_o,
	output reg clock_lost_o,
	output reg powered_down_o,
	output reg tx_standby_o,
	output reg rx_standby_o,
	output reg outputs_ready_o
);
	// ----------------------------------------
	// Pin edge detection
	// ----------------------------------------
	reg mclk_q;
	reg fsx_q;
	reg fsr_q;
	reg txclk_q;
	reg rxclk_q;
	reg pdn_q;
	wire mclk_rise;
	wire mclk_fall;
	wire fsx_rise;
	wire fsx_fall;
	wire fsr_rise;
	wire fsr_fall;
	wire txclk_rise;
	wire rxclk_fall;
	wire rxclk_edge;
	wire pdn_eff;

	// Previous levels of every pin clock and strobe
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			mclk_q <= 1'b0;
			fsx_q <= 1'b0;
			fsr_q <= 1'b0;
			txclk_q <= 1'b0;
			rxclk_q <= 1'b1; // Idle high, so no false mode edge
			pdn_q <= 1'b0;
		end else begin
			mclk_q <= master_clk_i;
			fsx_q <= transmit_frame_sync_i;
			fsr_q <= receive_frame_sync_i;
			txclk_q <= transmit_bit_clock_i;
			rxclk_q <= receive_bit_clock_i;
			pdn_q <= pdn_eff;
		end
	end

	// Edge strobes
	assign mclk_rise = master_clk_i & ~mclk_q;
	assign mclk_fall = ~master_clk_i & mclk_q;
	assign fsx_rise = transmit_frame_sync_i & ~fsx_q;
	assign fsx_fall = ~transmit_frame_sync_i & fsx_q;
	assign fsr_rise = receive_frame_sync_i & ~fsr_q;
	assign fsr_fall = ~receive_frame_sync_i & fsr_q;
	assign txclk_rise = transmit_bit_clock_i & ~txclk_q;
	assign rxclk_fall = ~receive_bit_clock_i & rxclk_q;
	assign rxclk_edge = receive_bit_clock_i ^ rxclk_q;

	// Undriven power down pin counts as high
	assign pdn_eff = ~power_down_n_oe_i | power_down_n_i;

	// ----------------------------------------
	// Word length
	// ----------------------------------------
	wire [4:0] word_len;
	wire [15:0] tx_frame_word;

	assign word_len = linear_mode_i ? `WORD_LEN_LINEAR : `WORD_LEN_COMPANDED;
	// Linear: sample then three zero pad bits; companded: byte on top
	assign tx_frame_word = linear_mode_i ? {tx_word_i[12:0], 3'h0}
		: {tx_word_i[7:0], 8'h00};

	// ----------------------------------------
	// Master clock loss watchdog
	// ----------------------------------------
	reg [7:0] loss_cnt;

	// Any master clock edge restarts the count
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			loss_cnt <= 8'h00;
			clock_lost_o <= 1'b1;
		end else if (mclk_rise || mclk_fall) begin
			loss_cnt <= 8'h00;
			clock_lost_o <= 1'b0;
		end else if (loss_cnt == `CLK_LOSS_CYCLES) begin
			clock_lost_o <= 1'b1;
		end else begin
			loss_cnt <= loss_cnt + 8'h01;
		end
	end

	// ----------------------------------------
	// Timing mode detection
	// ----------------------------------------
	reg [8:0] rxclk_idle;

	// Toggling receive bit clock means variable rate
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			rxclk_idle <= 9'h000;
			variable_rate_o <= 1'b0;
		end else if (rxclk_edge) begin
			rxclk_idle <= 9'h000;
			variable_rate_o <= 1'b1;
		end else if (mclk_rise) begin
			if (rxclk_idle != `FRAME_MCLK) begin
				rxclk_idle <= rxclk_idle + 9'h001;
			end else if (receive_bit_clock_i) begin
				variable_rate_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Power down and standby detection
	// ----------------------------------------
	reg [8:0] fsx_idle;
	reg [8:0] fsr_idle;

	// Power down follows the pin at once
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			powered_down_o <= 1'b0;
		end else begin
			powered_down_o <= ~pdn_eff;
		end
	end

	// Transmit sync idle for a frame period means held low
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			fsx_idle <= 9'h000;
			tx_standby_o <= 1'b1;
		end else if (fsx_rise) begin
			fsx_idle <= 9'h000;
			tx_standby_o <= 1'b0;
		end else if (mclk_rise) begin
			if (fsx_idle != `FRAME_MCLK) begin
				fsx_idle <= fsx_idle + 9'h001;
			end else begin
				tx_standby_o <= 1'b1;
			end
		end
	end

	// Receive sync idle for a frame period means held low
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			fsr_idle <= 9'h000;
			rx_standby_o <= 1'b1;
		end else if (fsr_rise) begin
			fsr_idle <= 9'h000;
			rx_standby_o <= 1'b0;
		end else if (mclk_rise) begin
			if (fsr_idle != `FRAME_MCLK) begin
				fsr_idle <= fsr_idle + 9'h001;
			end else begin
				rx_standby_o <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Power-up output hold-off
	// ----------------------------------------
	reg [2:0] warm_cnt;

	// Count transmit frames after reset or leaving power down
	always @(posedge ref_clk_i) begin
		if (rst_i || !pdn_eff || (pdn_eff && !pdn_q)) begin
			warm_cnt <= 3'h0;
			outputs_ready_o <= 1'b0;
		end else if (fsx_rise && warm_cnt != `WARMUP_FRAMES) begin
			warm_cnt <= warm_cnt + 3'h1;
		end else if (warm_cnt == `WARMUP_FRAMES) begin
			outputs_ready_o <= 1'b1;
		end
	end

	// ----------------------------------------
	// Transmit sequencer
	// ----------------------------------------
	reg tx_busy;
	reg tx_armed;
	reg [4:0] tx_bit;
	reg tx_load;
	reg tx_shift;
	wire tx_allow;
	wire tx_ok;

	// Outputs may drive only when every gate is open
	assign tx_allow = pdn_eff & ~clock_lost_o & outputs_ready_o;
	assign tx_ok = tx_allow & ~tx_standby_o;

	// Load and shift strobes for the shifter
	always @* begin
		tx_load = 1'b0;
		tx_shift = 1'b0;
		if (pdn_eff) begin
			if (variable_rate_o) begin
				if (fsx_rise) begin
					tx_load = 1'b1;
				end else if (tx_busy && txclk_rise && transmit_frame_sync_i) begin
					tx_load = (tx_bit == word_len);
					tx_shift = (tx_bit != word_len);
				end
			end else begin
				if (tx_armed && mclk_rise) begin
					tx_load = 1'b1;
				end else if (tx_busy && mclk_rise && tx_bit != word_len) begin
					tx_shift = 1'b1;
				end
			end
		end
	end

	// Slot state and bit count
	always @(posedge ref_clk_i) begin
		if (rst_i || !pdn_eff) begin
			tx_busy <= 1'b0;
			tx_armed <= 1'b0;
			tx_bit <= 5'h00;
			tx_word_taken_o <= 1'b0;
		end else begin
			tx_word_taken_o <= tx_load;
			if (tx_load) begin
				tx_busy <= 1'b1;
				tx_armed <= 1'b0;
				tx_bit <= 5'h01;
			end else if (tx_shift) begin
				tx_bit <= tx_bit + 5'h01;
			end
			if (!variable_rate_o && fsx_rise) begin
				tx_armed <= 1'b1;
			end
			if (variable_rate_o && fsx_fall) begin
				tx_busy <= 1'b0;
			end
			if (!variable_rate_o && tx_busy && mclk_fall && tx_bit == word_len) begin
				tx_busy <= 1'b0;
			end
		end
	end

	pcm_tx_shifter u_tx_shifter (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.load_i(tx_load),
		.shift_i(tx_shift),
		.word_i(tx_frame_word),
		.serial_o(serial_data_out_o)
	);

	// Pin drive enables; strobe low while the slot runs
	assign serial_data_out_oe_o = tx_busy & tx_ok;
	assign transmit_slot_strobe_n_oe_o = tx_busy & tx_ok;
	assign transmit_slot_strobe_n_o = ~tx_busy;

	// ----------------------------------------
	// Receive sequencer
	// ----------------------------------------
	reg rx_busy;
	reg [4:0] rx_bit;
	reg rx_done;
	wire rx_start;
	wire rx_capture;
	wire [15:0] rx_word;

	// Frame start while receive side is running
	assign rx_start = pdn_eff & fsr_rise & ~clock_lost_o;

	// Capture edge per timing mode
	assign rx_capture = rx_busy & (variable_rate_o
		? (rxclk_fall & receive_frame_sync_i)
		: mclk_fall);

	// Word assembly and completion
	always @(posedge ref_clk_i) begin
		if (rst_i || !pdn_eff) begin
			rx_busy <= 1'b0;
			rx_bit <= 5'h00;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (rx_start) begin
				rx_busy <= 1'b1;
				rx_bit <= 5'h00;
			end else if (rx_capture) begin
				rx_bit <= rx_bit + 5'h01;
				if (rx_bit + 5'h01 == word_len) begin
					rx_busy <= 1'b0;
					rx_done <= 1'b1;
				end
			end else if (variable_rate_o && fsr_fall) begin
				rx_busy <= 1'b0;
			end
		end
	end

	pcm_rx_shifter u_rx_shifter (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clear_i(rx_start), // Clear wins over a capture in the start cycle
		.capture_i(rx_capture),
		.bit_i(serial_data_in_i),
		.word_o(rx_word)
	);

	// Present the received word; linear splits sample and attenuation
	always @(posedge ref_clk_i) begin
		if (rst_i) begin
			rx_sample_o <= 13'h0000;
			rx_attenuation_o <= 3'h0;
			rx_word_valid_o <= 1'b0;
		end else begin
			rx_word_valid_o <= rx_done;
			if (rx_done) begin
				if (linear_mode_i) begin
					rx_sample_o <= rx_word[15:3];
					rx_attenuation_o <= rx_word[2:0];
				end else begin
					rx_sample_o <= {5'h00, rx_word[7:0]};
					rx_attenuation_o <= 3'h0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/dsp_serial_model.sv ***
// Purpose: DSP serial port facing the codec pins.
// Assumes: Master clock of eight reference cycles.
// Notes: Frame and vframe drive syncs and data in, record data out.
`timescale 1ns/10ps
`default_nettype none
module dsp_serial_model (
	// Clock
	input wire logic ref_clk_i,
	// From the codec
	input wire logic serial_data_out_i,
	input wire logic serial_data_out_oe_i,
	// To the codec
	output var logic master_clk_o,
	output var logic transmit_frame_sync_o,
	output var logic receive_frame_sync_o,
	output var logic serial_data_in_o,
	output var logic transmit_bit_clock_o,
	output var logic receive_bit_clock_o
);
	logic [2:0] ph = 3'h0;
	logic run = 1'h1;
	logic stuck = 1'h0;
	// Phase count; stops when the master clock is cut
	always @(posedge ref_clk_i) begin
		if (run)
			ph <= ph + 3'h1;
	end
	// Master clock changes off the sampling edge
	always @(negedge ref_clk_i) begin
		master_clk_o <= ph[2];
	end
	initial begin
		transmit_bit_clock_o = 1'h0;
		receive_bit_clock_o = 1'h1;
		transmit_frame_sync_o = 1'h0;
		receive_frame_sync_o = 1'h0;
		serial_data_in_o = 1'h0;
	end
	task automatic wait_ph(input logic [2:0] p);
		int k;
		@(negedge ref_clk_i);
		for (k = 0; k < 9 && ph != p; k++)
			@(negedge ref_clk_i);
		if (ph != p)
			stuck = 1'h1;
	endtask
	// One frame: syncs over one master fall, n bits each way
	task automatic frame(input logic tx_on, input logic rx_on, input logic [15:0] din, input int n,
		output logic [15:0] dout);
		dout = 16'h0000;
		wait_ph(3'h1);
		transmit_frame_sync_o = tx_on;
		receive_frame_sync_o = rx_on;
		serial_data_in_o = din[n-1];
		for (int i = n - 1; i >= 0; i--) begin
			wait_ph(3'h7);
			dout[i] = serial_data_out_oe_i ? serial_data_out_i : 1'hz;
			wait_ph(3'h1);
			transmit_frame_sync_o = 1'h0;
			receive_frame_sync_o = 1'h0;
			wait_ph(3'h5);
			serial_data_in_o = (i > 0) ? din[i-1] : ~din[0];
		end
	endtask
	// Variable rate frame: bit clocks from the model, rep is bit 1 of the repeat
	task automatic vframe(input logic [15:0] din, input int n, output logic [15:0] dout, output logic rep);
		dout = 16'h0000;
		@(negedge ref_clk_i);
		receive_bit_clock_o = 1'h0;
		repeat (3) @(negedge ref_clk_i);
		transmit_frame_sync_o = 1'h1;
		receive_frame_sync_o = 1'h1;
		serial_data_in_o = din[n-1];
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge ref_clk_i);
			dout[i] = serial_data_out_oe_i ? serial_data_out_i : 1'hz;
			transmit_bit_clock_o = 1'h1;
			receive_bit_clock_o = 1'h1;
			@(negedge ref_clk_i);
			transmit_bit_clock_o = 1'h0;
			receive_bit_clock_o = 1'h0;
			@(negedge ref_clk_i);
			serial_data_in_o = (i > 0) ? din[i-1] : ~din[0];
		end
		@(negedge ref_clk_i);
		rep = serial_data_out_oe_i ? serial_data_out_i : 1'hz;
		transmit_frame_sync_o = 1'h0;
		receive_frame_sync_o = 1'h0;
	endtask
endmodule
`default_nettype wire

// *** sim/pcm_port_properties.sv ***
// Purpose: Pin timing checks of the PCM port.
// Assumes: Fixed data rate, one reference clock.
// Notes: Bound into the port top.
`timescale 1ns/10ps
`default_nettype none
module pcm_port_properties (
	// Clock and pins in
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic master_clk_i,
	input wire logic power_down_n_i,
	input wire logic power_down_n_oe_i,
	// Outputs watched
	input wire logic serial_data_out_oe_o,
	input wire logic transmit_slot_strobe_n_o,
	input wire logic transmit_slot_strobe_n_oe_o,
	input wire logic tx_word_taken_o,
	input wire logic rx_word_valid_o,
	input wire logic variable_rate_o,
	input wire logic clock_lost_o,
	input wire logic powered_down_o,
	input wire logic tx_standby_o,
	input wire logic outputs_ready_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	logic [8:0] quiet;
	logic last_m;
	// Cycles since the last master edge
	always_ff @(posedge ref_clk_i) begin
		last_m <= master_clk_i;
		if (rst_i || master_clk_i != last_m)
			quiet <= 9'h000;
		else if (quiet != 9'h1ff)
			quiet <= quiet + 9'h001;
	end
	oe_gate_a: assert property (serial_data_out_oe_o |-> outputs_ready_o && !tx_standby_o
		&& !clock_lost_o && !powered_down_o) else $error("data out driven while gated");
	strobe_pair_a: assert property (serial_data_out_oe_o |-> transmit_slot_strobe_n_oe_o
		&& !transmit_slot_strobe_n_o) else $error("strobe not with data");
	slot_start_a: assert property ($rose(serial_data_out_oe_o) && !variable_rate_o |-> tx_word_taken_o
		&& $past(master_clk_i) && !$past(master_clk_i, 2)) else $error("slot not on master rise");
	slot_end_a: assert property ($fell(serial_data_out_oe_o) && !variable_rate_o && !clock_lost_o
		&& (power_down_n_i || !power_down_n_oe_i) && !powered_down_o && !tx_standby_o
		|-> !$past(master_clk_i) && $past(master_clk_i, 2)) else $error("slot not closed on master fall");
	rx_done_a: assert property (rx_word_valid_o && !variable_rate_o |-> !$past(master_clk_i, 2)
		&& $past(master_clk_i, 3)) else $error("word not after master fall");
	pdn_float_a: assert property (power_down_n_oe_i && !power_down_n_i |-> !serial_data_out_oe_o
		&& !transmit_slot_strobe_n_oe_o) else $error("outputs driven in power down");
	pdn_state_a: assert property ((power_down_n_oe_i && !power_down_n_i) [*6] |-> powered_down_o)
		else $error("power down not entered");
	pdn_open_a: assert property (!power_down_n_oe_i [*6] |-> !powered_down_o)
		else $error("open pin not read high");
	clk_loss_a: assert property (quiet > 9'h104 |-> clock_lost_o && !serial_data_out_oe_o)
		else $error("stopped clock not flagged");
endmodule
bind voice_codec_pcm_port pcm_port_properties chk (.ref_clk_i, .rst_i, .master_clk_i, .power_down_n_i,
	.power_down_n_oe_i, .serial_data_out_oe_o, .transmit_slot_strobe_n_o, .transmit_slot_strobe_n_oe_o,
	.tx_word_taken_o, .rx_word_valid_o, .variable_rate_o, .clock_lost_o, .powered_down_o,
	.tx_standby_o, .outputs_ready_o);
`default_nettype wire

// *** sim/voice_codec_pcm_port_bench.sv ***
// Purpose: Self-checking bench of the PCM port.
// Assumes: Fixed data rate, one variable rate frame at the end.
// Notes: Scenarios run in turn after reset.
`timescale 1ns/10ps
`default_nettype none
module voice_codec_pcm_port_bench;
	logic ref_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic master_clk_i, transmit_frame_sync_i, receive_frame_sync_i, serial_data_in_i;
	logic transmit_bit_clock_i, receive_bit_clock_i;
	logic power_down_n_i = 1'h0;
	logic power_down_n_oe_i = 1'h1;
	logic linear_mode_i = 1'h1;
	logic [15:0] tx_word_i = 16'h0000;
	logic serial_data_out_o, serial_data_out_oe_o, transmit_slot_strobe_n_o, transmit_slot_strobe_n_oe_o;
	logic tx_word_taken_o, rx_word_valid_o, variable_rate_o, clock_lost_o, powered_down_o;
	logic tx_standby_o, rx_standby_o, outputs_ready_o;
	logic [12:0] rx_sample_o, rx_s;
	logic [2:0] rx_attenuation_o, rx_a;
	logic [15:0] dout;
	int rx_n = 0;
	int fail_count = 0;
	int compares = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	voice_codec_pcm_port dut (.ref_clk_i, .rst_i, .master_clk_i, .transmit_frame_sync_i,
		.receive_frame_sync_i, .transmit_bit_clock_i, .receive_bit_clock_i,
		.serial_data_in_i, .power_down_n_i, .power_down_n_oe_i, .linear_mode_i, .serial_data_out_o,
		.serial_data_out_oe_o, .transmit_slot_strobe_n_o, .transmit_slot_strobe_n_oe_o, .tx_word_i,
		.tx_word_taken_o, .rx_sample_o, .rx_attenuation_o, .rx_word_valid_o, .variable_rate_o,
		.clock_lost_o, .powered_down_o, .tx_standby_o, .rx_standby_o, .outputs_ready_o);
	dsp_serial_model dsp (.ref_clk_i, .serial_data_out_i(serial_data_out_o),
		.serial_data_out_oe_i(serial_data_out_oe_o), .master_clk_o(master_clk_i),
		.transmit_frame_sync_o(transmit_frame_sync_i), .receive_frame_sync_o(receive_frame_sync_i),
		.serial_data_in_o(serial_data_in_i), .transmit_bit_clock_o(transmit_bit_clock_i),
		.receive_bit_clock_o(receive_bit_clock_i));
	// Keep the latest received word
	always @(posedge ref_clk_i) begin
		if (rx_word_valid_o) begin
			rx_s <= rx_sample_o;
			rx_a <= rx_attenuation_o;
			rx_n <= rx_n + 1;
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic final_report;
		chk("model wait", 16'h0000, 16'(dsp.stuck));
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One frame both ways; live says data out should drive
	task automatic xfer(input logic [15:0] txw, input logic [15:0] din, input logic live, input logic rx_ok);
		int n;
		int c;
		n = linear_mode_i ? 16 : 8;
		c = rx_n;
		tx_word_i = txw;
		dsp.frame(1'h1, 1'h1, din, n, dout);
		repeat (3) @(negedge ref_clk_i);
		if (!live)
			chk("idle dout", 16'hzzzz, dout);
		else if (n == 16)
			chk("dout", {txw[12:0], 3'h0}, dout);
		else
			chk("dout", {8'h00, txw[7:0]}, dout);
		chk("rx count", 16'(c + rx_ok), 16'(rx_n));
		if (rx_ok && n == 16)
			chk("rx word", din, {rx_s, rx_a});
		else if (rx_ok)
			chk("rx word", {5'h00, din[7:0], 3'h0}, {rx_s, rx_a});
	endtask
	task automatic t_warmup;
		repeat (3) xfer(16'h1234, 16'h8001, 1'h0, 1'h1);
		dsp.frame(1'h1, 1'h1, 16'h0000, 16, dout);
		xfer(16'hf0ff, 16'hfffe, 1'h1, 1'h1);
	endtask
	task automatic t_words;
		logic [15:0] w [4] = '{16'h1001, 16'hea5a, 16'h1fff, 16'h0000};
		for (int i = 0; i < 4; i++)
			xfer(w[i], w[i] ^ 16'hc3a5, 1'h1, 1'h1);
		linear_mode_i = 1'h0;
		xfer(16'h5581, 16'h00c7, 1'h1, 1'h1);
		xfer(16'h007e, 16'h0f80, 1'h1, 1'h1);
		linear_mode_i = 1'h1;
	endtask
	task automatic t_clock_stop;
		dsp.run = 1'h0;
		repeat (300) @(negedge ref_clk_i);
		chk("clock lost", 16'h0001, 16'(clock_lost_o));
		chk("oe stopped", 16'h0000, 16'(serial_data_out_oe_o));
		dsp.run = 1'h1;
		repeat (16) @(negedge ref_clk_i);
		chk("clock back", 16'h0000, 16'(clock_lost_o));
		xfer(16'h1555, 16'h2aaa, 1'h1, 1'h1);
	endtask
	task automatic t_power_down;
		power_down_n_i = 1'h0;
		repeat (10) @(negedge ref_clk_i);
		chk("powered down", 16'h0001, 16'(powered_down_o));
		xfer(16'h1234, 16'h4321, 1'h0, 1'h0);
		power_down_n_oe_i = 1'h0;
		repeat (10) @(negedge ref_clk_i);
		chk("open pin", 16'h0000, 16'(powered_down_o));
		t_warmup();
		power_down_n_i = 1'h1;
		power_down_n_oe_i = 1'h1;
	endtask
	task automatic t_standby;
		tx_word_i = 16'h0123;
		repeat (17) dsp.frame(1'h0, 1'h0, 16'ha5c3, 16, dout);
		chk("tx standby", 16'h0001, 16'(tx_standby_o));
		chk("rx standby", 16'h0001, 16'(rx_standby_o));
		repeat (17) dsp.frame(1'h0, 1'h1, 16'ha5c3, 16, dout);
		chk("rx awake", 16'h0000, 16'(rx_standby_o));
		chk("tx still idle", 16'h0001, 16'(tx_standby_o));
		chk("tx floats", 16'hzzzz, dout);
		repeat (17) dsp.frame(1'h1, 1'h0, 16'ha5c3, 16, dout);
		chk("rx asleep", 16'h0001, 16'(rx_standby_o));
		chk("tx live", 16'h0918, dout);
	endtask
	// One variable rate frame both ways, with repeat and release
	task automatic t_variable;
		logic rep;
		int c;
		logic [15:0] w;
		w = 16'h1a5c;
		c = rx_n;
		tx_word_i = w;
		dsp.vframe(16'h6c35, 16, dout, rep);
		chk("variable mode", 16'h0001, 16'(variable_rate_o));
		repeat (3) @(negedge ref_clk_i);
		chk("vdr oe off", 16'h0000, 16'(serial_data_out_oe_o));
		chk("vdr dout", {w[12:0], 3'h0}, dout);
		chk("vdr repeat", {15'h0000, w[12]}, 16'(rep));
		chk("vdr rx count", 16'(c + 1), 16'(rx_n));
		chk("vdr rx word", 16'h6c35, {rx_s, rx_a});
	endtask
	// Hang guard
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		fail_count++;
		final_report();
	end
	initial begin
		repeat (5) @(negedge ref_clk_i);
		rst_i = 1'h0;
		power_down_n_i = 1'h1;
		chk("oe at reset", 16'h0000, 16'(serial_data_out_oe_o));
		t_warmup();
		t_words();
		t_clock_stop();
		t_power_down();
		t_standby();
		t_variable();
		final_report();
	end
endmodule
`default_nettype wire
